// ### common/iocps_defines.svh
`ifndef IOCPS_DEFINES_SVH
`define IOCPS_DEFINES_SVH
`define IOCPS_PORT_SEL_LSB_DEFAULT 9
`define IOCPS_PORT_SEL_LSB_ALT 8
`define IOCPS_DATA_LSB 0
`define IOCPS_CTRL_ADVANCE_BIT 7
`define IOCPS_IN_PORT_RX 2'h0
`define IOCPS_IN_PORT_STATUS 2'h1
`define IOCPS_IN_PORT_PROM 2'h2
`define IOCPS_OUT_PORT_TX 2'h0
`define IOCPS_OUT_PORT_CTRL 2'h1
`define IOCPS_OUT_PORT_PADDR 2'h2
`define IOCPS_OUT_PORT_PDATA 2'h3
`define IOCPS_OUT_LATCH_RESET 8'h00
`define IOCPS_IN_PULLUP 8'hff
`endif

// ### common/iocps_pkg.sv
package iocps_pkg;
    typedef enum logic [1:0] {
        IOCPS_SERIAL_UART,
        IOCPS_SERIAL_DISABLED,
        IOCPS_SERIAL_ABSENT,
        IOCPS_SERIAL_BYPASS
    } iocps_serial_mode_type;
    typedef enum logic {
        IOCPS_SEL_REG,
        IOCPS_SEL_ADDR
    } iocps_sel_src_type;
    typedef logic [7:0] iocps_byte_type;
endpackage

// ### common/iocps_latch_if.sv
`timescale 1ns/1ps
interface iocps_latch_if;
    logic [3:0] port_en;
    logic [7:0] wr_data;
    logic [7:0] q [4];
    modport decoder (output port_en, output wr_data, input q);
    modport latches (input port_en, input wr_data, output q);
endinterface

// ### hdl/iocps_out_latches.sv
`timescale 1ns/1ps
`include "iocps_defines.svh"
module iocps_out_latches (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Decoder side
    iocps_latch_if.latches lat
);
    // Each latch loads only on its own enable, else holds
    for (genvar g = 0; g < 4; g++) begin : g_lat
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                lat.q[g] <= `IOCPS_OUT_LATCH_RESET;
            end else if (lat.port_en[g]) begin
                lat.q[g] <= lat.wr_data; // RULE_14
            end
        end
    end
endmodule // iocps_out_latches

// ### hdl/iocps_card.sv
// Behaviour
// (RULE_01) Register-select lines, qualified, select the card
// (RULE_02) Address enable forced active in that mode
// (RULE_03) Register-select output feeds address-decode enable
// (RULE_04) Qualifier may be forced permanently active
// (RULE_05) Port select from bits 9-10 or 8-9
// (RULE_06) Output data from muxed bus or data bus
// (RULE_07) Absent serial chip: ports 0,1 read high
// (RULE_08) Disabled transceiver never drives input ports
// (RULE_09) Bypass passes serial lines as single bits
// (RULE_10) System keeps terminal ports for terminal only
// (RULE_11) Ports 2, 9, 10, 11 serve programmer
// (RULE_12) No other access during programming
// (RULE_13) Strobe plus enables selects one port
// (RULE_14) Output latches hold until readdressed
// (RULE_15) Ports 0/1 rx and status; 8/9 tx, control
// (RULE_16) Control bit seven sets reader advance latch
// (RULE_17) Jumper choices are build-time parameters
`timescale 1ns/1ps
`include "iocps_defines.svh"
module iocps_card #(
    // Build-time jumper choices (RULE_17)
    parameter iocps_pkg::iocps_sel_src_type SEL_SRC = iocps_pkg::IOCPS_SEL_REG,
    parameter bit FORCE_QUALIFIER = 1'b0,
    parameter bit PORT_SEL_ALT = 1'b0,
    parameter bit DATA_FROM_SEP_BUS = 1'b0,
    parameter iocps_pkg::iocps_serial_mode_type SERIAL_MODE =
        iocps_pkg::IOCPS_SERIAL_UART,
    parameter logic [1:0] REG_SELECT_MATCH = 2'h0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Processor bus
    input wire logic [13:0] i_muxed_addr_data_bus,
    input wire logic [7:0] i_separate_data_bus,
    input wire logic i_reg_select_lo,
    input wire logic i_reg_select_hi,
    input wire logic i_memory_mode_two,
    input wire logic i_high_address_match,
    input wire logic i_io_in,
    input wire logic i_io_out,
    output logic [7:0] o_input_data_bus,
    // Transceiver side
    input wire logic [7:0] i_rx_data,
    input wire logic [7:0] i_rx_status,
    input wire logic i_rx_output_enable_n,
    input wire logic i_status_output_enable_n,
    input wire logic i_tx_serial_bit,
    input wire logic i_terminal_serial_in,
    input wire logic i_rx_start,
    output logic o_tx_start,
    output logic o_terminal_serial_out,
    output logic o_tape_reader_advance,
    // General input ports and programmer
    input wire logic [7:0] i_in_port3,
    input wire logic [7:0] i_prom_data_out,
    output logic [7:0] o_out_tx_data,
    output logic [7:0] o_out_prom_control,
    output logic [7:0] o_out_prom_address,
    output logic [7:0] o_out_prom_data
);
    iocps_latch_if lat ();
    logic [13:0] bus_s1, bus_s2;
    logic [7:0] db_s1, db_s2;
    logic [7:0] ctl_s1, ctl_s2;
    logic [7:0] rxd_s1, rxd_s2, rxs_s1, rxs_s2;
    logic [7:0] p3_s1, p3_s2, pd_s1, pd_s2;
    logic in_s2_prev, out_s2_prev;
    logic reg_sel, addr_en, card_en, qual;
    logic [1:0] port_sel;
    logic in_strobe, out_strobe;
    logic [3:0] in_en;
    logic [7:0] port0_data, port1_data;

    // Two-stage synchronisers on every pin
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_s1 <= 14'h0000;
            bus_s2 <= 14'h0000;
            db_s1 <= 8'h00;
            db_s2 <= 8'h00;
            ctl_s1 <= 8'h00;
            ctl_s2 <= 8'h00;
            rxd_s1 <= 8'h00;
            rxd_s2 <= 8'h00;
            rxs_s1 <= 8'h00;
            rxs_s2 <= 8'h00;
            p3_s1 <= 8'h00;
            p3_s2 <= 8'h00;
            pd_s1 <= 8'h00;
            pd_s2 <= 8'h00;
        end else begin
            bus_s1 <= i_muxed_addr_data_bus;
            bus_s2 <= bus_s1;
            db_s1 <= i_separate_data_bus;
            db_s2 <= db_s1;
            ctl_s1 <= {i_reg_select_lo, i_reg_select_hi, i_memory_mode_two,
                       i_high_address_match, i_io_in, i_io_out,
                       i_rx_output_enable_n, i_status_output_enable_n};
            ctl_s2 <= ctl_s1;
            rxd_s1 <= i_rx_data;
            rxd_s2 <= rxd_s1;
            rxs_s1 <= i_rx_status;
            rxs_s2 <= rxs_s1;
            p3_s1 <= i_in_port3;
            p3_s2 <= p3_s1;
            pd_s1 <= i_prom_data_out;
            pd_s2 <= pd_s1;
        end
    end

    logic [2:0] ser_s1, ser_s2;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ser_s1 <= 3'h7;
            ser_s2 <= 3'h7;
        end else begin
            ser_s1 <= {i_tx_serial_bit, i_terminal_serial_in, i_rx_start};
            ser_s2 <= ser_s1;
        end
    end

    // Module select
    assign reg_sel = ({ctl_s2[7], ctl_s2[6]} == REG_SELECT_MATCH);
    always_comb begin
        if (SEL_SRC == iocps_pkg::IOCPS_SEL_REG) begin
            addr_en = 1'b1; // RULE_02
            card_en = reg_sel & addr_en; // RULE_01
        end else begin
            addr_en = ctl_s2[4];
            card_en = addr_en & reg_sel; // RULE_03
        end
    end
    assign qual = FORCE_QUALIFIER ? 1'b1 : ctl_s2[5]; // RULE_04
    assign port_sel = PORT_SEL_ALT ?
        bus_s2[`IOCPS_PORT_SEL_LSB_ALT +: 2] :
        bus_s2[`IOCPS_PORT_SEL_LSB_DEFAULT +: 2]; // RULE_05

    // Strobes act on their rising edge, one enable per operation
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            in_s2_prev <= 1'b0;
            out_s2_prev <= 1'b0;
        end else begin
            in_s2_prev <= ctl_s2[3];
            out_s2_prev <= ctl_s2[2];
        end
    end
    assign in_strobe = card_en & qual & ctl_s2[3] & ~in_s2_prev; // RULE_13
    assign out_strobe = card_en & qual & ctl_s2[2] & ~out_s2_prev; // RULE_13
    assign in_en = in_strobe ? (4'h1 << port_sel) : 4'h0; // RULE_13
    assign lat.port_en = out_strobe ? (4'h1 << port_sel) : 4'h0; // RULE_13
    assign lat.wr_data = DATA_FROM_SEP_BUS ? db_s2 :
        bus_s2[`IOCPS_DATA_LSB +: 8]; // RULE_06

    iocps_out_latches u_latches (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .lat(lat)
    );

    // Input port 0/1 sources by serial mode
    always_comb begin
        port0_data = `IOCPS_IN_PULLUP;
        port1_data = `IOCPS_IN_PULLUP;
        unique case (SERIAL_MODE)
            iocps_pkg::IOCPS_SERIAL_UART: begin
                if (!ctl_s2[1]) port0_data = rxd_s2; // RULE_15
                if (!ctl_s2[0]) port1_data = rxs_s2; // RULE_15
            end
            iocps_pkg::IOCPS_SERIAL_DISABLED: begin
                port0_data = `IOCPS_IN_PULLUP; // RULE_08
            end
            iocps_pkg::IOCPS_SERIAL_ABSENT: begin
                port0_data = `IOCPS_IN_PULLUP; // RULE_07
                port1_data = `IOCPS_IN_PULLUP; // RULE_07
            end
            iocps_pkg::IOCPS_SERIAL_BYPASS: begin
                port0_data = {7'h7f, ser_s2[1]}; // RULE_09
            end
        endcase
    end

    // Input data bus register, held between reads
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_input_data_bus <= 8'h00;
        end else if (in_strobe) begin
            unique case (1'b1)
                in_en[`IOCPS_IN_PORT_RX]: o_input_data_bus <= port0_data;
                in_en[`IOCPS_IN_PORT_STATUS]: o_input_data_bus <= port1_data;
                in_en[`IOCPS_IN_PORT_PROM]: o_input_data_bus <= pd_s2; // RULE_11
                in_en[3]: o_input_data_bus <= p3_s2;
            endcase
        end
    end

    // Transmit start pulse from the port 8 enable
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_start <= 1'b0;
        end else begin
            o_tx_start <= lat.port_en[`IOCPS_OUT_PORT_TX] &&
                SERIAL_MODE == iocps_pkg::IOCPS_SERIAL_UART; // RULE_15
        end
    end

    // Serial output: resets high; in bypass port 8 latch bit 0 passes through, low until written
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_terminal_serial_out <= 1'b1;
        end else if (SERIAL_MODE == iocps_pkg::IOCPS_SERIAL_BYPASS) begin
            o_terminal_serial_out <= lat.q[`IOCPS_OUT_PORT_TX][0]; // RULE_09
        end else begin
            o_terminal_serial_out <= ser_s2[2];
        end
    end

    // Tape reader advance: set wins over clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tape_reader_advance <= 1'b0;
        end else if (lat.port_en[`IOCPS_OUT_PORT_CTRL] &&
                     lat.wr_data[`IOCPS_CTRL_ADVANCE_BIT]) begin
            o_tape_reader_advance <= 1'b1; // RULE_16
        end else if (!ser_s2[0]) begin
            o_tape_reader_advance <= 1'b0; // RULE_16
        end
    end

    // Latched output ports to pins (RULE_11 ports 9-11)
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_out_tx_data <= `IOCPS_OUT_LATCH_RESET;
            o_out_prom_control <= `IOCPS_OUT_LATCH_RESET;
            o_out_prom_address <= `IOCPS_OUT_LATCH_RESET;
            o_out_prom_data <= `IOCPS_OUT_LATCH_RESET;
        end else begin
            o_out_tx_data <= lat.q[`IOCPS_OUT_PORT_TX]; // RULE_15
            o_out_prom_control <= lat.q[`IOCPS_OUT_PORT_CTRL]; // RULE_11
            o_out_prom_address <= lat.q[`IOCPS_OUT_PORT_PADDR]; // RULE_11
            o_out_prom_data <= lat.q[`IOCPS_OUT_PORT_PDATA]; // RULE_11
        end
    end
endmodule // iocps_card

// ### verif/iocps_card_properties.sv
`timescale 1ns/1ps
module iocps_card_properties #(
    parameter logic [1:0] REG_SELECT_MATCH = 2'h0,
    // Only the standard jumper set is modelled here
    parameter bit ACTIVE = 1'b1
) (
    // Watched pins
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [13:0] i_muxed_addr_data_bus,
    input wire logic i_reg_select_lo,
    input wire logic i_reg_select_hi,
    input wire logic i_memory_mode_two,
    input wire logic i_io_in,
    input wire logic i_io_out,
    input wire logic i_rx_output_enable_n,
    input wire logic i_rx_start,
    input wire logic [7:0] o_input_data_bus,
    input wire logic o_tx_start,
    input wire logic o_tape_reader_advance
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n || !ACTIVE);
    wire logic sel = i_memory_mode_two
        && {i_reg_select_lo, i_reg_select_hi} == REG_SELECT_MATCH;
    wire logic p0 = sel && i_muxed_addr_data_bus[10:9] == 2'h0;
    wire logic p1 = sel && i_muxed_addr_data_bus[10:9] == 2'h1;
    tx_pulse_a: assert property (o_tx_start |=> !o_tx_start)
        else $error("tx pulse long");
    tx_write_a: assert property (
        $rose(i_io_out) && p0 |-> ##[3:5] o_tx_start) else $error("no tx");
    tx_unsel_a: assert property (
        $rose(i_io_out) && !sel |=> !o_tx_start [*6]) else $error("tx unsel");
    adv_set_a: assert property (
        $rose(i_io_out) && p1 && i_muxed_addr_data_bus[7]
        |-> ##[3:5] o_tape_reader_advance) else $error("no advance");
    adv_cause_a: assert property (
        $rose(o_tape_reader_advance) |-> $past(i_io_out, 2)) else $error("adv");
    adv_clear_a: assert property (
        $fell(i_rx_start) && !i_io_out
        |-> ##[1:5] !o_tape_reader_advance) else $error("adv stuck");
    rx_off_a: assert property (
        $rose(i_io_in) && p0 && i_rx_output_enable_n
        |-> ##[2:5] o_input_data_bus == 8'hff) else $error("rx off");
    in_hold_a: assert property (
        $changed(o_input_data_bus) |-> $past(i_io_in, 2)) else $error("in");
    tx_seen_c: cover property ($rose(o_tx_start));
    adv_seen_c: cover property ($rose(o_tape_reader_advance));
    rx_off_c: cover property ($rose(i_io_in) && i_rx_output_enable_n);
endmodule // iocps_card_properties
bind iocps_card iocps_card_properties #(
    .REG_SELECT_MATCH(REG_SELECT_MATCH),
    .ACTIVE(SEL_SRC == iocps_pkg::IOCPS_SEL_REG && !FORCE_QUALIFIER &&
        !PORT_SEL_ALT && SERIAL_MODE == iocps_pkg::IOCPS_SERIAL_UART))
    iocps_card_properties_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_muxed_addr_data_bus(i_muxed_addr_data_bus),
    .i_reg_select_lo(i_reg_select_lo), .i_reg_select_hi(i_reg_select_hi),
    .i_memory_mode_two(i_memory_mode_two), .i_io_in(i_io_in),
    .i_io_out(i_io_out), .i_rx_output_enable_n(i_rx_output_enable_n),
    .i_rx_start(i_rx_start), .o_input_data_bus(o_input_data_bus),
    .o_tx_start(o_tx_start),
    .o_tape_reader_advance(o_tape_reader_advance));

// ### verif/iocps_cpu.sv
`timescale 1ns/1ps
module iocps_cpu (
    // Clock
    input wire logic i_clk,
    // Card bus
    output logic [13:0] o_mad,
    output logic o_hi,
    output logic o_mm,
    output logic o_in,
    output logic o_out,
    input wire logic [7:0] i_data
);
    initial {o_mad, o_hi, o_mm, o_in, o_out} = '0;
    // One port access; reserved ports are reached only from here
    task automatic xfer(
        input logic wr, input logic [1:0] port, input logic [7:0] data,
        input logic hi, input logic mm, output logic [7:0] rd);
        @(negedge i_clk);
        // Junk above the port field; bit 8 repeats the port's high bit
        o_mad = {3'h5, port, port[1], data};
        o_hi = hi;
        o_mm = mm;
        repeat (3) @(negedge i_clk);
        if (wr) o_out = 1'b1;
        else o_in = 1'b1;
        repeat (5) @(negedge i_clk);
        rd = i_data;
        {o_in, o_out} = 2'h0;
        repeat (3) @(negedge i_clk);
        // Released bus carries inverted residue
        o_mad = ~o_mad;
        repeat (2) @(negedge i_clk);
    endtask
endmodule // iocps_cpu

// ### verif/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic oe_n = 1'b0;
    logic tx_bit = 1'b1;
    logic rx_start = 1'b1;
    logic [7:0] ins [4] = '{default: 8'h00};
    logic [7:0] wv [4] = '{8'h3a, 8'h05, 8'hc6, 8'h9f};
    logic [7:0] rv [4] = '{8'h5a, 8'h81, 8'hc3, 8'h3c};
    logic [13:0] muxed_addr_data_bus;
    logic [7:0] r, in_bus, tx_d, p_ctl, p_adr, p_dat;
    logic hi, mm, io_in, io_out, tx_start, ser_out, adv;
    logic ham = 1'b0;
    logic term_in = 1'b1;
    logic [7:0] sdb = 8'h00;
    logic [7:0] in_b, b_tx_d, b_adr;
    logic b_ser;
    logic [7:0] in_cd [2];
    int errors = 0;
    int tests_run = 0;
    int pulses = 0;
    wire logic [31:0] outs = {p_dat, p_adr, p_ctl, tx_d};
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) if (tx_start === 1'b1) pulses++;
    iocps_cpu iocps_cpu_i (.i_clk(i_clk), .o_mad(muxed_addr_data_bus), .o_hi(hi),
        .o_mm(mm), .o_in(io_in), .o_out(io_out), .i_data(in_bus));
    iocps_card iocps_card_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_muxed_addr_data_bus(muxed_addr_data_bus), .i_separate_data_bus(8'h00),
        .i_reg_select_lo(1'b0), .i_reg_select_hi(hi),
        .i_memory_mode_two(mm), .i_high_address_match(1'b0),
        .i_io_in(io_in), .i_io_out(io_out), .o_input_data_bus(in_bus),
        .i_rx_data(ins[0]), .i_rx_status(ins[1]),
        .i_rx_output_enable_n(oe_n), .i_status_output_enable_n(oe_n),
        .i_tx_serial_bit(tx_bit), .i_terminal_serial_in(1'b1),
        .i_rx_start(rx_start), .o_tx_start(tx_start),
        .o_terminal_serial_out(ser_out), .o_tape_reader_advance(adv),
        .i_in_port3(ins[3]), .i_prom_data_out(ins[2]),
        .o_out_tx_data(tx_d), .o_out_prom_control(p_ctl),
        .o_out_prom_address(p_adr), .o_out_prom_data(p_dat));
    // Address-line select, forced qualifier, bits 8-9, data bus, bypass
    iocps_card #(.SEL_SRC(iocps_pkg::IOCPS_SEL_ADDR), .FORCE_QUALIFIER(1'b1),
        .PORT_SEL_ALT(1'b1), .DATA_FROM_SEP_BUS(1'b1),
        .SERIAL_MODE(iocps_pkg::IOCPS_SERIAL_BYPASS)) iocps_card_b_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_muxed_addr_data_bus(muxed_addr_data_bus),
        .i_separate_data_bus(sdb), .i_reg_select_lo(1'b0),
        .i_reg_select_hi(hi), .i_memory_mode_two(mm),
        .i_high_address_match(ham), .i_io_in(io_in), .i_io_out(io_out),
        .o_input_data_bus(in_b), .i_rx_data(ins[0]), .i_rx_status(ins[1]),
        .i_rx_output_enable_n(oe_n), .i_status_output_enable_n(oe_n),
        .i_tx_serial_bit(tx_bit), .i_terminal_serial_in(term_in),
        .i_rx_start(rx_start), .o_tx_start(), .o_terminal_serial_out(b_ser),
        .o_tape_reader_advance(), .i_in_port3(ins[3]),
        .i_prom_data_out(ins[2]), .o_out_tx_data(b_tx_d),
        .o_out_prom_control(), .o_out_prom_address(b_adr),
        .o_out_prom_data());
    // Module 1 cards: serial chip removed (0) or tied off (1)
    for (genvar k = 0; k < 2; k++) begin : g_ser
        iocps_card #(.REG_SELECT_MATCH(2'h1), .SERIAL_MODE(k == 0 ?
            iocps_pkg::IOCPS_SERIAL_ABSENT :
            iocps_pkg::IOCPS_SERIAL_DISABLED)) iocps_card_i (
            .i_clk(i_clk), .i_rst_n(i_rst_n), .i_muxed_addr_data_bus(muxed_addr_data_bus),
            .i_separate_data_bus(8'h00), .i_reg_select_lo(1'b0),
            .i_reg_select_hi(hi), .i_memory_mode_two(mm),
            .i_high_address_match(1'b0), .i_io_in(io_in),
            .i_io_out(io_out), .o_input_data_bus(in_cd[k]),
            .i_rx_data(ins[0]), .i_rx_status(ins[1]),
            .i_rx_output_enable_n(oe_n), .i_status_output_enable_n(oe_n),
            .i_tx_serial_bit(tx_bit), .i_terminal_serial_in(1'b1),
            .i_rx_start(rx_start), .o_tx_start(), .o_terminal_serial_out(),
            .o_tape_reader_advance(), .i_in_port3(ins[3]),
            .i_prom_data_out(ins[2]), .o_out_tx_data(),
            .o_out_prom_control(), .o_out_prom_address(),
            .o_out_prom_data());
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge i_clk);
        i_rst_n = 1'b1;
        `CHK("tx_data", 8'h00, tx_d)
        `CHK("serial_out", 1'b1, ser_out)
        $display("test reset done");
        for (int p = 0; p < 4; p++) begin
            iocps_cpu_i.xfer(1'b1, p[1:0], wv[p], 1'b0, 1'b1, r);
        end
        iocps_cpu_i.xfer(1'b1, 2'h0, 8'hee, 1'b1, 1'b1, r);
        iocps_cpu_i.xfer(1'b1, 2'h0, 8'hee, 1'b0, 1'b0, r);
        `CHK("tx_pulses", 1, pulses)
        $display("test writes done");
        for (int p = 0; p < 4; p++) begin
            ins[p] = rv[p];
            iocps_cpu_i.xfer(1'b0, p[1:0], 8'h00, 1'b0, 1'b1, r);
            `CHK("in_port", rv[p], r)
            `CHK("out_port", wv[p], outs[8*p+:8])
        end
        oe_n = 1'b1;
        for (int p = 0; p < 2; p++) begin
            iocps_cpu_i.xfer(1'b0, p[1:0], 8'h00, 1'b0, 1'b1, r);
            `CHK("in_off", 8'hff, r)
        end
        $display("test reads done");
        iocps_cpu_i.xfer(1'b1, 2'h1, 8'h80, 1'b0, 1'b1, r);
        `CHK("advance", 1'b1, adv)
        rx_start = 1'b0;
        repeat (4) @(negedge i_clk);
        rx_start = 1'b1;
        repeat (2) @(negedge i_clk);
        `CHK("advance", 1'b0, adv)
        tx_bit = 1'b0;
        repeat (6) @(negedge i_clk);
        `CHK("serial_out", 1'b0, ser_out)
        $display("test terminal done");
        sdb = 8'h77;
        iocps_cpu_i.xfer(1'b1, 2'h1, 8'h00, 1'b0, 1'b0, r);
        `CHK("b_unselected", 8'h00, b_adr)
        ham = 1'b1;
        iocps_cpu_i.xfer(1'b1, 2'h1, 8'h00, 1'b0, 1'b0, r);
        `CHK("b_port_alt", 8'h77, b_adr)
        `CHK("a_no_qualifier", 8'h80, p_ctl)
        sdb = 8'h01;
        iocps_cpu_i.xfer(1'b1, 2'h0, 8'h00, 1'b0, 1'b0, r);
        `CHK("b_tx_data", 8'h01, b_tx_d)
        `CHK("b_serial_out", 1'b1, b_ser)
        sdb = 8'h00;
        term_in = 1'b0;
        iocps_cpu_i.xfer(1'b1, 2'h0, 8'hff, 1'b0, 1'b0, r);
        `CHK("b_serial_out", 1'b0, b_ser)
        iocps_cpu_i.xfer(1'b0, 2'h0, 8'h00, 1'b0, 1'b0, r);
        `CHK("b_bypass_in", 8'hfe, in_b)
        oe_n = 1'b0;
        for (int p = 0; p < 2; p++) begin
            iocps_cpu_i.xfer(1'b0, p[1:0], 8'h00, 1'b1, 1'b1, r);
            `CHK("absent_in", 8'hff, in_cd[0])
            `CHK("disabled_in", 8'hff, in_cd[1])
        end
        $display("test alternate jumpers done");
        end_sim();
    end
endmodule // tb
